// file: shared/charge_consts.vh
/*
 * Timing counts and timer defaults for the charge controller.
 * Assumes a 25 MHz core clock; long counts are overridable by parameters.
 */
`ifndef CHARGE_CONSTS_VH
`define CHARGE_CONSTS_VH

`define CLK_HZ             25000000
`define TICK_MS            1
`define TICK_CYCLES        ((`CLK_HZ / 1000) * `TICK_MS)
`define TRICKLE_MIN_PER_UNIT 30
`define TOTAL_HR_PER_UNIT  3
`define TRICKLE_TICKS_PER_UNIT (`TRICKLE_MIN_PER_UNIT * 60 * 1000 / `TICK_MS)
`define TOTAL_TICKS_PER_UNIT   (`TOTAL_HR_PER_UNIT * 3600 * 1000 / `TICK_MS)
`define TIMER_UNITS_RST    8'h01
`define TICK_W             32

`endif

// file: rtl/sync2.v
/*
 * Two-flop synchroniser for one pin level.
 * Assumes the input is asynchronous to i_clk.
 */
`timescale 1ns/1ps
module sync2 (
    input  wire i_clk,
    input  wire i_rstn,
    input  wire i_d,
    output wire o_q
);
    reg meta_reg;
    reg q_reg;

    always @(posedge i_clk) begin
        if (!i_rstn) begin
            meta_reg <= 1'b0;
            q_reg    <= 1'b0;
        end else begin
            meta_reg <= i_d;
            q_reg    <= meta_reg;
        end
    end

    assign o_q = q_reg;
endmodule

// file: rtl/charge_control.v
/*
 * Charge phase sequencer, supply path selection, switch cycle control,
 * safety timer and open-drain status lines of a one-cell charger.
 * Assumes analog comparators deliver levels on the i_ ports; all are
 * asynchronous and pass sync2 first. Oscillator edges arrive as a pin.
 */
`timescale 1ns/1ps
`include "charge_consts.vh"

module charge_control #(
    parameter TICK_CYCLES   = `TICK_CYCLES,
    parameter TRICKLE_TICKS = `TRICKLE_TICKS_PER_UNIT,
    parameter TOTAL_TICKS   = `TOTAL_TICKS_PER_UNIT
) (
    input  wire       i_clk,
    input  wire       i_rstn,
    input  wire       i_enable,
    input  wire       i_adapter_supply_input_ok,
    input  wire       i_usb_supply_input_ok,
    input  wire       i_headroom_ok,
    input  wire       i_batt_above_trickle,
    input  wire       i_batt_at_cv,
    input  wire       i_batt_below_recharge,
    input  wire       i_batt_below_short,
    input  wire       i_current_below_full,
    input  wire       i_peak_trip,
    input  wire       i_osc,
    input  wire       i_thermistor_in_window,
    input  wire       i_die_hot,
    input  wire       i_die_cool,
    input  wire       i_timer_grounded,
    input  wire [7:0] i_timer_units,
    output reg        o_adapter_path_switch,
    output reg        o_usb_path_switch,
    output reg        o_reverse_block,
    output reg        o_usb_limit_active,
    output reg        o_high_side_on,
    output reg        o_low_side_on,
    output reg        o_trickle_current,
    output reg        o_voltage_loop,
    output reg        o_short_flag,
    output reg        o_low_peak_limit,
    output reg        o_freq_foldback,
    output wire       o_status_line_a_out,
    output reg        o_status_line_a_oe,
    output wire       o_status_line_b_out,
    output reg        o_status_line_b_oe,
    output reg  [5:0] o_phase
);
    localparam [5:0] ST_IDLE    = 6'h01;
    localparam [5:0] ST_TRICKLE = 6'h02;
    localparam [5:0] ST_CC      = 6'h04;
    localparam [5:0] ST_CV      = 6'h08;
    localparam [5:0] ST_FULL    = 6'h10;
    localparam [5:0] ST_FAULT   = 6'h20;

    wire en_s, ac_s, usb_s, hr_s, tc_s, cv_s, rch_s, sh_s, full_s;
    wire pk_s, osc_s, ntc_s, hot_s, cool_s, tgnd_s;
    wire [13:0] raw = {i_enable, i_adapter_supply_input_ok, i_usb_supply_input_ok,
                       i_headroom_ok, i_batt_above_trickle, i_batt_at_cv,
                       i_batt_below_recharge, i_batt_below_short,
                       i_current_below_full, i_peak_trip, i_osc,
                       i_thermistor_in_window, i_die_hot, i_die_cool};
    wire [13:0] syn;
    // Every comparator level is asynchronous; nothing reads it before two flops
    genvar g;
    generate
        for (g = 0; g < 14; g = g + 1) begin : g_sync
            sync2 u_sync (
                .i_clk  (i_clk),
                .i_rstn (i_rstn),
                .i_d    (raw[g]),
                .o_q    (syn[g])
            );
        end
    endgenerate
    // Timer pin has its own pair, outside the comparator vector
    sync2 u_tmr (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_d    (i_timer_grounded),
        .o_q    (tgnd_s)
    );
    assign {en_s, ac_s, usb_s, hr_s, tc_s, cv_s, rch_s, sh_s, full_s,
            pk_s, osc_s, ntc_s, hot_s, cool_s} = syn;

    reg  [5:0]  state_reg;
    reg  [5:0]  state_next;
    reg         en_d_reg;
    reg         osc_d_reg;
    reg         rch_d_reg;
    reg         hs_reg;
    reg         thermal_off_reg;
    reg  [31:0] tick_cnt_reg;
    reg  [31:0] trickle_cnt_reg;
    reg  [31:0] total_cnt_reg;
    reg         fold_div_reg;

    wire supply_ok = ac_s | usb_s;
    wire osc_rise  = osc_s & ~osc_d_reg;
    wire en_toggle = en_s ^ en_d_reg;
    // A level would retry a dead cell forever; only a fresh drop or an enable toggle leaves a fault
    wire rch_drop  = rch_s & ~rch_d_reg;
    // Fault pauses on thermal or thermistor keep the phase; the switch and the safety timer stop
    wire pause     = thermal_off_reg | ~ntc_s;
    wire charging  = (state_reg == ST_TRICKLE) | (state_reg == ST_CC) | (state_reg == ST_CV);
    wire timer_run = charging & ~tgnd_s & ~pause;
    // Tick length trades timer resolution against counter width
    wire tick      = (tick_cnt_reg == TICK_CYCLES - 1);
    // Limits scale linearly with the timer setting
    // Setting is read live; change it only while no charge runs
    wire [39:0] trickle_lim = TRICKLE_TICKS * i_timer_units;
    wire [39:0] total_lim   = TOTAL_TICKS * i_timer_units;
    // Expiry only while the timer runs, so a paused or grounded timer never ends a charge
    wire trickle_exp = timer_run & ({8'h00, trickle_cnt_reg} >= trickle_lim);
    wire total_exp   = timer_run & ({8'h00, total_cnt_reg} >= total_lim);
    wire active      = charging & supply_ok & hr_s & en_s & ~pause;

    // Hot is tested first, so a late cool reading cannot cancel a shutdown
    always @(posedge i_clk) begin
        if (!i_rstn) begin
            thermal_off_reg <= 1'b0;
        end else if (hot_s) begin
            thermal_off_reg <= 1'b1;
        end else if (cool_s) begin
            thermal_off_reg <= 1'b0;
        end
    end

    // Prescaled timebase; counters hold while paused
    always @(posedge i_clk) begin
        if (!i_rstn) begin
            tick_cnt_reg    <= 32'h00000000;
            trickle_cnt_reg <= 32'h00000000;
            total_cnt_reg   <= 32'h00000000;
        end else if (!charging) begin
            tick_cnt_reg    <= 32'h00000000;
            trickle_cnt_reg <= 32'h00000000;
            total_cnt_reg   <= 32'h00000000;
        end else if (timer_run) begin
            tick_cnt_reg <= tick ? 32'h00000000 : tick_cnt_reg + 32'h00000001;
            if (tick) begin
                total_cnt_reg <= total_cnt_reg + 32'h00000001;
                if (state_reg == ST_TRICKLE)
                    trickle_cnt_reg <= trickle_cnt_reg + 32'h00000001;
            end
        end
    end

    // Enable low wins over every phase except the cycle that sees the toggle
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (en_s & supply_ok)
                    state_next = ST_TRICKLE;
            end
            ST_TRICKLE: begin
                if (total_exp | trickle_exp)
                    state_next = ST_FAULT;
                else if (tc_s & active)
                    state_next = ST_CC;
            end
            ST_CC: begin
                if (total_exp)
                    state_next = ST_FAULT;
                else if (cv_s & active)
                    state_next = ST_CV;
            end
            ST_CV: begin
                if (total_exp)
                    state_next = ST_FAULT;
                else if (full_s & active)
                    state_next = ST_FULL;
            end
            ST_FULL: begin
                if (rch_s)
                    state_next = ST_TRICKLE;
            end
            ST_FAULT: begin
                if (rch_drop | en_toggle)
                    state_next = ST_TRICKLE;
            end
            default: state_next = ST_IDLE;
        endcase
        if (!en_s & !en_toggle)
            state_next = ST_IDLE;
    end

    always @(posedge i_clk) begin
        if (!i_rstn) begin
            state_reg <= ST_IDLE;
            en_d_reg  <= 1'b0;
            osc_d_reg <= 1'b0;
            rch_d_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            en_d_reg  <= en_s;
            osc_d_reg <= osc_s;
            rch_d_reg <= rch_s;
        end
    end

    // Fold back: only every second oscillator edge starts a cycle
    always @(posedge i_clk) begin
        if (!i_rstn)
            fold_div_reg <= 1'b0;
        else if (osc_rise)
            fold_div_reg <= ~fold_div_reg;
    end
    wire cycle_start = osc_rise & (~sh_s | fold_div_reg);

    // Trip ends the on time; no trip keeps it on across cycles
    // Trip is tested before the start, so a tripped cycle never turns on
    always @(posedge i_clk) begin
        if (!i_rstn)
            hs_reg <= 1'b0;
        else if (!active)
            hs_reg <= 1'b0;
        else if (pk_s)
            hs_reg <= 1'b0;
        else if (cycle_start)
            hs_reg <= 1'b1;
    end

    // All outputs but the tied-low status drivers registered so no decode glitch reaches a power switch
    always @(posedge i_clk) begin
        if (!i_rstn) begin
            o_adapter_path_switch <= 1'b0;
            o_usb_path_switch     <= 1'b0;
            o_reverse_block       <= 1'b1;
            o_usb_limit_active    <= 1'b0;
            o_high_side_on        <= 1'b0;
            o_low_side_on         <= 1'b0;
            o_trickle_current     <= 1'b0;
            o_voltage_loop        <= 1'b0;
            o_short_flag          <= 1'b0;
            o_low_peak_limit      <= 1'b0;
            o_freq_foldback       <= 1'b0;
            o_status_line_a_oe    <= 1'b0;
            o_status_line_b_oe    <= 1'b0;
            o_phase               <= ST_IDLE;
        end else begin
            o_adapter_path_switch <= ac_s;
            o_usb_path_switch     <= ~ac_s & usb_s;
            o_usb_limit_active    <= ~ac_s & usb_s;
            o_reverse_block       <= ~supply_ok;
            o_high_side_on        <= hs_reg;
            o_low_side_on         <= ~hs_reg & active;
            o_trickle_current     <= state_reg == ST_TRICKLE;
            o_voltage_loop        <= state_reg == ST_CV;
            o_short_flag          <= sh_s;
            o_low_peak_limit      <= sh_s;
            o_freq_foldback       <= sh_s;
            o_phase               <= state_reg;
            // Idle is the cycle before trickle; it must not read as done or fault
            if (!supply_ok | !hr_s | !en_s | (state_reg == ST_IDLE)) begin
                o_status_line_b_oe <= 1'b0;
                o_status_line_a_oe <= 1'b0;
            end else if (charging & ~pause) begin
                o_status_line_b_oe <= 1'b1;
                o_status_line_a_oe <= 1'b1;
            end else begin
                o_status_line_b_oe <= 1'b1;
                o_status_line_a_oe <= 1'b0;
            end
        end
    end

    // Open drain: only ever drive low
    assign o_status_line_a_out = 1'b0;
    assign o_status_line_b_out = 1'b0;
endmodule

// file: verif/charge_monitor.sv
/*
 * Checker for charge_control: supply paths, switch timing, status lines, phases.
 * Assumes one clock with synchronous active-low reset; bound below by name.
 */
`timescale 1ns/1ps
module charge_monitor (
    input wire       i_clk,
    input wire       i_rstn,
    input wire       i_enable,
    input wire       i_headroom_ok,
    input wire       i_adapter_supply_input_ok,
    input wire       i_usb_supply_input_ok,
    input wire       o_adapter_path_switch,
    input wire       o_usb_path_switch,
    input wire       o_reverse_block,
    input wire       o_high_side_on,
    input wire       o_low_side_on,
    input wire       o_voltage_loop,
    input wire       o_status_line_a_out,
    input wire       o_status_line_a_oe,
    input wire       o_status_line_b_out,
    input wire       o_status_line_b_oe,
    input wire [5:0] o_phase
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);
    a_no_overlap: assert property (!(o_high_side_on && o_low_side_on))
        else $error("high and low side switches on together");
    a_path_excl: assert property (o_adapter_path_switch |-> !o_usb_path_switch)
        else $error("both path switches closed");
    a_adapter_wins: assert property (i_adapter_supply_input_ok [*8] |-> !o_usb_path_switch)
        else $error("usb path closed with adapter present");
    a_no_supply_off: assert property ((!i_adapter_supply_input_ok && !i_usb_supply_input_ok) [*8]
        |-> !o_adapter_path_switch && !o_usb_path_switch && o_reverse_block)
        else $error("path open or no reverse blocking without supply");
    a_status_full: assert property ((o_phase == 6'h10 && i_enable && i_headroom_ok
        && (i_adapter_supply_input_ok || i_usb_supply_input_ok)) [*5]
        |-> o_status_line_b_oe && !o_status_line_a_oe)
        else $error("status code wrong at charge full");
    a_status_fault: assert property ((o_phase == 6'h20 && i_enable && i_headroom_ok
        && (i_adapter_supply_input_ok || i_usb_supply_input_ok)) [*5]
        |-> o_status_line_b_oe && !o_status_line_a_oe)
        else $error("status code wrong at fault");
    a_status_idle: assert property (o_phase == 6'h01 |-> !o_status_line_a_oe && !o_status_line_b_oe)
        else $error("status line pulled low while idle");
    a_open_drain: assert property (!o_status_line_a_out && !o_status_line_b_out)
        else $error("status line driven high");
    a_cc_after_tc: assert property ($rose(o_phase[2]) |-> $past(o_phase[1]))
        else $error("constant current entered not from trickle");
    a_cv_after_cc: assert property ($rose(o_phase[3]) |-> $past(o_phase[2]))
        else $error("constant voltage entered not from constant current");
    a_vloop_in_cv: assert property (o_voltage_loop |-> o_phase[3])
        else $error("voltage loop active outside constant voltage");
endmodule

bind charge_control charge_monitor u_charge_monitor (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_enable(i_enable), .i_headroom_ok(i_headroom_ok),
    .i_adapter_supply_input_ok(i_adapter_supply_input_ok),
    .i_usb_supply_input_ok(i_usb_supply_input_ok), .o_adapter_path_switch(o_adapter_path_switch),
    .o_usb_path_switch(o_usb_path_switch), .o_reverse_block(o_reverse_block),
    .o_high_side_on(o_high_side_on), .o_low_side_on(o_low_side_on),
    .o_voltage_loop(o_voltage_loop), .o_status_line_a_out(o_status_line_a_out),
    .o_status_line_a_oe(o_status_line_a_oe), .o_status_line_b_out(o_status_line_b_out),
    .o_status_line_b_oe(o_status_line_b_oe), .o_phase(o_phase)
);

// file: verif/battery_pack_model.sv
/*
 * Battery pack comparators and status pull-ups seen by the charger.
 * Assumes the bench sets cell voltage in millivolts; thresholds are fixed except the CV_MV parameter.
 */
`timescale 1ns/1ps
module battery_pack_model #(
    parameter CV_MV = 16'h1068
) (
    input  wire [15:0] i_batt_mv,
    input  wire        i_line_a_out,
    input  wire        i_line_a_oe,
    input  wire        i_line_b_out,
    input  wire        i_line_b_oe,
    output wire        o_above_trickle,
    output wire        o_at_cv,
    output wire        o_below_recharge,
    output wire        o_below_short,
    output wire        o_line_a,
    output wire        o_line_b
);
    assign o_above_trickle  = i_batt_mv >= 16'h0BB8;
    assign o_at_cv          = i_batt_mv >= CV_MV;
    assign o_below_recharge = i_batt_mv < 16'h0FA0;
    assign o_below_short    = i_batt_mv < 16'h07D0;
    // Pull-ups give the high level; a released line never floats here
    assign o_line_a = i_line_a_oe ? i_line_a_out : 1'b1;
    assign o_line_b = i_line_b_oe ? i_line_b_out : 1'b1;
endmodule

// file: verif/testbench.sv
/*
 * Self-checking bench for charge_control with a battery pack model.
 * Assumes short timer counts: 4-cycle tick, 10 and 30 ticks per unit.
 */
`timescale 1ns/1ps
module testbench;
    reg         i_clk = 1'b0;
    reg         i_rstn = 1'b0;
    reg         en = 1'b0, ac = 1'b0, usb = 1'b0, hr = 1'b1, osc = 1'b0, peak = 1'b0;
    reg         thermistor_input = 1'b1, hot = 1'b0, cool = 1'b1, tgnd = 1'b0, full_i = 1'b0;
    reg  [15:0] batt = 16'h09C4;
    reg  [7:0]  units = 8'h02;
    wire        abv, atcv, brch, bsh, line_a, line_b, sw_ac, sw_usb, rev, lim, hs, ls;
    wire        tric, vloop, sh, lpk, fold, a_out, a_oe, b_out, b_oe;
    wire [5:0]  phase;
    integer     fails = 0, comparisons = 0, n;

    always #20 i_clk = ~i_clk;

    charge_control #(.TICK_CYCLES(4), .TRICKLE_TICKS(10), .TOTAL_TICKS(30)) u_charge_control (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_enable(en), .i_adapter_supply_input_ok(ac),
        .i_usb_supply_input_ok(usb), .i_headroom_ok(hr), .i_batt_above_trickle(abv),
        .i_batt_at_cv(atcv), .i_batt_below_recharge(brch), .i_batt_below_short(bsh),
        .i_current_below_full(full_i), .i_peak_trip(peak), .i_osc(osc),
        .i_thermistor_in_window(thermistor_input), .i_die_hot(hot), .i_die_cool(cool),
        .i_timer_grounded(tgnd), .i_timer_units(units), .o_adapter_path_switch(sw_ac),
        .o_usb_path_switch(sw_usb), .o_reverse_block(rev), .o_usb_limit_active(lim),
        .o_high_side_on(hs), .o_low_side_on(ls), .o_trickle_current(tric),
        .o_voltage_loop(vloop), .o_short_flag(sh), .o_low_peak_limit(lpk),
        .o_freq_foldback(fold), .o_status_line_a_out(a_out), .o_status_line_a_oe(a_oe),
        .o_status_line_b_out(b_out), .o_status_line_b_oe(b_oe), .o_phase(phase));
    battery_pack_model u_battery_pack_model (
        .i_batt_mv(batt), .i_line_a_out(a_out), .i_line_a_oe(a_oe), .i_line_b_out(b_out),
        .i_line_b_oe(b_oe), .o_above_trickle(abv), .o_at_cv(atcv), .o_below_recharge(brch),
        .o_below_short(bsh), .o_line_a(line_a), .o_line_b(line_b));

    task cyc(input integer k);
        repeat (k) @(negedge i_clk);
    endtask
    task chk(input string name, input [7:0] exp, input [7:0] got);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                $display("ERROR %s expected %h seen %h", name, exp, got);
                fails = fails + 1;
            end
        end
    endtask
    // Bounded wait; a phase that never comes ends the run
    task wait_phase(input [5:0] exp, input integer lim);
        begin
            n = 0;
            while (phase !== exp && n < lim) begin
                @(negedge i_clk);
                n = n + 1;
            end
            chk("phase", {2'b00, exp}, {2'b00, phase});
            if (phase !== exp) close_out;
        end
    endtask
    task toggle_enable;
        begin
            en = 1'b0;
            cyc(6);
            en = 1'b1;
        end
    endtask
    task close_out;
        begin
            if (fails == 0 && comparisons > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    initial begin
        #(40 * 20000);
        $display("ERROR run_time expected finish seen hang");
        fails = fails + 1;
        close_out;
    end

    initial begin
        cyc(4);
        i_rstn = 1'b1;
        cyc(2);
        chk("idle", 8'h06, {phase, rev, sw_ac});
        chk("lines", 8'h03, {6'h00, line_b, line_a});
        // Both supplies at once: system should avoid it, adapter must still win
        ac = 1'b1;
        usb = 1'b1;
        en = 1'b1;
        wait_phase(6'h02, 10);
        chk("paths", 8'h06, {5'h00, tric, sw_ac, sw_usb});
        chk("lines", 8'h00, {6'h00, line_b, line_a});
        wait_phase(6'h20, 100);
        chk("trickle_time", 8'h01, {7'h00, n >= 74 && n <= 86});
        chk("fault_oe", 8'h02, {6'h00, b_oe, a_oe});
        tgnd = 1'b1;
        units = 8'h01;
        toggle_enable;
        wait_phase(6'h02, 12);
        cyc(80);
        chk("held", 8'h02, {2'b00, phase});
        osc = 1'b1;
        cyc(6);
        chk("hs_on", 8'h02, {6'h00, hs, ls});
        osc = 1'b0;
        cyc(2);
        osc = 1'b1;
        cyc(6);
        chk("hs_span", 8'h02, {6'h00, hs, ls});
        peak = 1'b1;
        cyc(6);
        chk("ls_on", 8'h01, {6'h00, hs, ls});
        peak = 1'b0;
        osc = 1'b0;
        batt = 16'h05DC;
        cyc(6);
        chk("short", 8'h07, {5'h00, sh, lpk, fold});
        batt = 16'h0DAC;
        wait_phase(6'h04, 12);
        batt = 16'h1068;
        wait_phase(6'h08, 12);
        chk("vloop", 8'h01, {7'h00, vloop});
        full_i = 1'b1;
        wait_phase(6'h10, 12);
        chk("lines", 8'h01, {6'h00, line_b, line_a});
        tgnd = 1'b0;
        full_i = 1'b0;
        batt = 16'h0DAC;
        wait_phase(6'h02, 12);
        wait_phase(6'h20, 160);
        chk("total_time", 8'h01, {7'h00, n >= 110 && n <= 130});
        tgnd = 1'b1;
        toggle_enable;
        wait_phase(6'h04, 20);
        hot = 1'b1;
        cool = 1'b0;
        cyc(6);
        chk("hot", 8'h01, {6'h00, line_b, line_a});
        hot = 1'b0;
        cool = 1'b1;
        cyc(6);
        chk("cool", 8'h00, {6'h00, line_b, line_a});
        thermistor_input = 1'b0;
        cyc(6);
        chk("ntc_out", 8'h01, {6'h00, line_b, line_a});
        thermistor_input = 1'b1;
        cyc(6);
        chk("ntc_in", 8'h00, {6'h00, line_b, line_a});
        hr = 1'b0;
        cyc(6);
        chk("headroom", 8'h03, {6'h00, line_b, line_a});
        hr = 1'b1;
        ac = 1'b0;
        cyc(6);
        chk("usb_path", 8'h03, {5'h00, sw_ac, sw_usb, lim});
        usb = 1'b0;
        cyc(6);
        chk("no_supply", 8'h01, {5'h00, sw_ac, sw_usb, rev});
        chk("lines", 8'h03, {6'h00, line_b, line_a});
        close_out;
    end
endmodule
